// >>> dcsl_pkg.sv
package dcsl_pkg;
  // ***********************************************
  // timing
  // ***********************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int FLASH_PERIOD_MS = 1000;
  localparam int TIMEOUT_S = 120;
  // half of a flash period in clock cycles
  localparam int FLASH_HALF_CYC = FLASH_PERIOD_MS * 1000000 / 2 / CLK_PERIOD_NS;
  // timeout expressed as flash half periods
  localparam int TIMEOUT_HALVES = TIMEOUT_S * 1000 * 2 / FLASH_PERIOD_MS;
  localparam int SYNC_SETTLE_CYC = 4;

  // ***********************************************
  // register map (byte addresses)
  // ***********************************************
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h8;
  localparam logic CTRL_FLASH_EN_RST = 1'b1;
  localparam int CTRL_FLASH_EN_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;

  // ***********************************************
  // error codes with special handling (octal in comments)
  // ***********************************************
  localparam logic [7:0] ERR_DRV1_HOME = 8'h10; // 020
  localparam logic [7:0] ERR_HDR_CRC = 8'h60; // 140
  localparam logic [7:0] ERR_DENSITY = 8'ha0; // 240

  typedef enum logic [1:0] {
    DCSL_CFG_SETTLE = 2'b00,
    DCSL_CFG_SAMPLE = 2'b01,
    DCSL_CFG_HOLD = 2'b11
  } dcsl_cfg_t;
endpackage

// >>> dcsl_top.sv
`timescale 1ns/1ps
// Summary of operation
// [R01] switches 1-3 all zero selects normal mode
// [R02] switch 4 picks compatibility mode 1/2
// [R03] switch 5 swaps left/right unit mapping
// [R04] switches 6 and 7 ignored in normal
// [R05] switch 8 sets one or two drives
// [R06] diagnostic routine chosen by all eight switches
// [R07] indicator 9 lit while processor runs
// [R08] indicator 1 lit in normal mode
// [R09] indicator 2 lit while waiting for host, normal mode only
// [R10] indicator 3 writing, indicator 4 reading
// [R11] indicators 5-8 show class, 5 msb
// [R12] class zero when no error recorded
// [R13] class 0001 for operator faults
// [R14] class 0010 for density or key
// [R15] class 0011 address, 0100 count/memory
// [R16] classes 0101, 0110, 0111 mapped
// [R17] classes 1000 and 1001 mapped
// [R18] classes 1010, 1011, 1100 mapped
// [R19] classes 1101 and 1110 mapped
// [R20] class 1111 for write failures
// [R21] class updates at once, init clears
// [R22] flash drive led in normal mode on an error other than density, 020 or 140
// [R23] codes 020, 140 leave error bit clear
// [R24] self-test failure pattern on indicators
// [R25] switches sampled once after power-up
// [R26] flash and timeout counters restart per error
module dcsl_top #(
  parameter int FLASH_HALF = dcsl_pkg::FLASH_HALF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] switch_pins,
  input wire logic proc_running,
  input wire logic host_wait,
  input wire logic disk_writing,
  input wire logic disk_reading,
  input wire logic host_init,
  input wire logic err_valid,
  input wire logic [7:0] error_code_register,
  input wire logic err_unit,
  input wire logic [1:0] head_loaded,
  input wire logic selftest_fail,
  input wire logic [3:0] selftest_code,
  output logic [8:0] board_led,
  output logic [1:0] activity_led,
  output logic normal_mode,
  output logic mode1_compat,
  output logic unit_swap,
  output logic two_drives,
  output logic [7:0] diag_select,
  output logic diag_start,
  output logic control_status_register_err
);
  import dcsl_pkg::*;

  // ***********************************************
  // switch synchroniser and one-time sampling
  // ***********************************************
  logic [7:0] sw_s1;
  logic [7:0] sw_s2;
  logic [7:0] sw_s3;
  logic [7:0] sw_hold;
  logic cfg_sampled;
  logic sample_seen;
  dcsl_cfg_t cfg_state;
  dcsl_cfg_t next_cfg_state;
  logic [2:0] settle_cnt;
  wire sw_stable = (sw_s2 == sw_s3);
  wire settle_done = (settle_cnt == 3'(SYNC_SETTLE_CYC - 1));

  // the bank is slow, so three flops cost little and keep a bouncing rocker out
  // three stages; only s2/s3 are compared, s1 feeds s2 alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_s1 <= 8'h00;
      sw_s2 <= 8'h00;
      sw_s3 <= 8'h00;
    end else begin
      sw_s1 <= switch_pins;
      sw_s2 <= sw_s1;
      sw_s3 <= sw_s2;
    end
  end

  // wait for the pipe to fill, then take one stable reading
  always_comb begin
    next_cfg_state = cfg_state;
    case (cfg_state)
      DCSL_CFG_SETTLE: if (settle_done) next_cfg_state = DCSL_CFG_SAMPLE;
      DCSL_CFG_SAMPLE: if (sw_stable) next_cfg_state = DCSL_CFG_HOLD;
      DCSL_CFG_HOLD: next_cfg_state = DCSL_CFG_HOLD;
      default: next_cfg_state = DCSL_CFG_SETTLE;
    endcase
  end

  wire take_sample = (cfg_state == DCSL_CFG_SAMPLE) && sw_stable;

  // limitation: moving a rocker after sampling takes effect only at the next power-up
  // held until the next power-up; a host init does not resample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_state <= DCSL_CFG_SETTLE;
      settle_cnt <= 3'h0;
      sw_hold <= 8'h00;
      cfg_sampled <= 1'b0;
      sample_seen <= 1'b0;
    end else begin
      cfg_state <= next_cfg_state;
      sample_seen <= take_sample; // one-edge echo of the sampling edge
      if (!settle_done) settle_cnt <= settle_cnt + 3'h1;
      if (take_sample) begin
        sw_hold <= sw_s3; // R25
        cfg_sampled <= 1'b1;
      end
    end
  end

  // ***********************************************
  // configuration decode
  // ***********************************************
  // bit i of the bank is switch position i+1
  wire dec_normal = cfg_sampled && (sw_hold[2:0] == 3'h0); // R01
  wire dec_mode1 = dec_normal && sw_hold[3]; // R02
  wire dec_swap = dec_normal && sw_hold[4]; // R03
  // positions 6 and 7 feed nothing in normal mode
  wire dec_two = dec_normal && sw_hold[7]; // R04 R05
  // diagnostic settings leave mode, mapping and count low so nothing acts on them
  wire dec_diag = cfg_sampled && !dec_normal;

  // configuration outputs, diagnostic start one cycle after sampling
  // the start pulse waits an edge so diag_select already names the routine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      normal_mode <= 1'b0;
      mode1_compat <= 1'b0;
      unit_swap <= 1'b0;
      two_drives <= 1'b0;
      diag_select <= 8'h00;
      diag_start <= 1'b0;
    end else begin
      normal_mode <= dec_normal;
      mode1_compat <= dec_mode1;
      unit_swap <= dec_swap;
      two_drives <= dec_two;
      diag_select <= dec_diag ? sw_hold : 8'h00; // R06
      diag_start <= sample_seen && dec_diag; // R06
    end
  end

  // ***********************************************
  // ahb-lite slave
  // ***********************************************
  logic ph_write;
  logic ph_valid;
  logic [3:0] ph_addr;
  logic flash_en;
  logic clear_req;
  logic [3:0] err_class;
  logic [7:0] err_code;
  logic csr_err;
  logic flash_on;
  logic flash_phase;
  logic flash_unit;

  // hsize is not checked: only whole aligned words are ever moved
  wire addr_take = hsel && hready && htrans[1];
  wire [3:0] a_idx = haddr[3:0];
  wire sel_cfg = (a_idx == ADDR_CONFIG);
  wire sel_sts = (a_idx == ADDR_STATUS);
  wire sel_ctl = (a_idx == ADDR_CONTROL);
  wire [31:0] rd_cfg = {19'h0, cfg_sampled, dec_two, dec_swap,
                        dec_mode1, dec_normal, sw_hold};
  wire [31:0] rd_sts = {7'h0, board_led, selftest_fail, flash_unit,
                        flash_on, csr_err, err_code, err_class};
  wire [31:0] rd_ctl = {31'h0, flash_en};
  // unmapped words read zero and still answer okay
  wire [31:0] rd_mux = sel_cfg ? rd_cfg :
                       sel_sts ? rd_sts :
                       sel_ctl ? rd_ctl : 32'h0;
  wire wr_ctl = ph_valid && ph_write && (ph_addr == ADDR_CONTROL);

  // zero wait states: hreadyout drops only in reset, so no transfer is stretched
  // read data is captured at the address edge so it comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      ph_write <= 1'b0;
      ph_valid <= 1'b0;
      ph_addr <= 4'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ph_valid <= addr_take;
      ph_write <= hwrite;
      ph_addr <= a_idx;
      if (addr_take && !hwrite) hrdata <= rd_mux;
    end
  end

  // control: flash enable steers the drive leds, clear acts like init
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_en <= CTRL_FLASH_EN_RST;
      clear_req <= 1'b0;
    end else begin
      clear_req <= wr_ctl && hwdata[CTRL_CLEAR_BIT];
      if (wr_ctl) flash_en <= hwdata[CTRL_FLASH_EN_BIT];
    end
  end

  // ***********************************************
  // error code to class
  // ***********************************************
  // codes are octal numbers carried as plain binary; bit 4 of the result marks
  // a listed code, so an unlisted code leaves the display alone
  function automatic logic [4:0] class_of(input logic [7:0] code);
    logic [4:0] r;
    r = 5'h00;
    case (code)
      8'h40: r = 5'h11; // 100 write protect
      8'hf0: r = 5'h11; // 360 drive not ready
      8'ha0: r = 5'h12; // 240 density
      8'ha8: r = 5'h12; // 250 density key
      8'h20: r = 5'h13; // 040 drive or track address
      8'h98: r = 5'h14; // 230 word count
      8'he8: r = 5'h14; // 350 nonexistent memory
      8'hb0: r = 5'h15; // 260 indeterminate density
      8'h68: r = 5'h16; // 150 seek mismatch
      8'h60: r = 5'h17; // 140 header check
      8'h80: r = 5'h18; // 200 data check
      8'h38: r = 5'h19; // 070 sector unrecoverable
      8'h50: r = 5'h19; // 120
      8'h58: r = 5'h19; // 130
      8'h70: r = 5'h19; // 160
      8'h78: r = 5'h19; // 170
      8'h48: r = 5'h1a; // 110 no read data
      8'h90: r = 5'h1b; // 220 sub-controller
      8'hd0: r = 5'h1b; // 320
      8'hd8: r = 5'h1b; // 330
      8'he0: r = 5'h1c; // 340 master controller
      8'h08: r = 5'h1d; // 010 drive failure
      8'h10: r = 5'h1d; // 020
      8'h18: r = 5'h1d; // 030
      8'h28: r = 5'h1d; // 050
      8'h88: r = 5'h1e; // 210 interface parity
      8'hb8: r = 5'h1f; // 270 write failure
      8'hf8: r = 5'h1f; // 370 format write failure
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  // ***********************************************
  // error class capture
  // ***********************************************
  wire [4:0] cls = class_of(error_code_register); // R13 R14 R15 R16 R17 R18 R19 R20
  // unknown codes stop here and never reach the status bit
  wire err_known = err_valid && cls[4];
  // 020 and 140 are logged without the status error bit
  wire sets_csr = (error_code_register != ERR_DRV1_HOME) &&
                  (error_code_register != ERR_HDR_CRC); // R23
  wire wants_flash = err_known && sets_csr && flash_en && dec_normal &&
                     (error_code_register != ERR_DENSITY); // R22
  wire do_clear = host_init || clear_req;

  // the exact code is kept beside the class so software can read the cause
  // a new error wins over an init in the same cycle, so no event is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_class <= 4'h0; // R12
      err_code <= 8'h00;
      csr_err <= 1'b0;
    end else if (err_known) begin
      err_class <= cls[3:0]; // R21
      err_code <= error_code_register;
      csr_err <= sets_csr; // R23
    end else if (do_clear) begin
      err_class <= 4'h0; // R21
      err_code <= 8'h00;
      csr_err <= 1'b0;
    end
  end

  // ***********************************************
  // drive activity flash
  // ***********************************************
  logic [31:0] half_cnt;
  logic [7:0] halves;
  wire half_done = (half_cnt == 32'(FLASH_HALF - 1));
  wire time_up = half_done && (halves == 8'(TIMEOUT_HALVES - 1));

  // one drive flashes at a time; the newest qualifying error takes it over
  // the half period is a parameter so a bench can shorten the two minutes
  // counters restart on every qualifying error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_on <= 1'b0;
      flash_phase <= 1'b0;
      flash_unit <= 1'b0;
      half_cnt <= 32'h0;
      halves <= 8'h00;
    end else if (wants_flash) begin
      flash_on <= 1'b1; // R22
      flash_phase <= 1'b1;
      flash_unit <= err_unit;
      half_cnt <= 32'h0; // R26
      halves <= 8'h00; // R26
    end else if (do_clear || time_up) begin
      flash_on <= 1'b0; // R22
      flash_phase <= 1'b0;
      half_cnt <= 32'h0;
      halves <= 8'h00;
    end else if (flash_on) begin
      half_cnt <= half_done ? 32'h0 : half_cnt + 32'h1; // R26
      if (half_done) begin
        flash_phase <= !flash_phase;
        halves <= halves + 8'h1;
      end
    end
  end

  // head load shows on a drive's led whenever that drive is not flashing
  // logical unit to physical drive: index 0 left, 1 right
  wire flash_phys = flash_unit ^ dec_swap;
  logic [1:0] next_act;
  always_comb begin
    next_act = head_loaded;
    if (flash_on) next_act[flash_phys] = flash_phase; // R22
  end

  // ***********************************************
  // board indicators
  // ***********************************************
  // indicators 3 and 4 follow the disk in both modes
  // a failed power-up test overrides everything with its fixed pattern
  wire halt_fail = selftest_fail;
  wire l1 = !halt_fail && dec_normal; // R08 R24
  wire l2 = halt_fail || (dec_normal && host_wait); // R09 R24
  wire l3 = !halt_fail && disk_writing; // R10 R24
  wire l4 = !halt_fail && disk_reading; // R10 R24
  wire [3:0] l58 = halt_fail ? selftest_code : err_class; // R11 R24
  wire l9 = !halt_fail && proc_running; // R07 R24
  // board_led[0] is indicator 1; indicator 5 (msb) is board_led[4]
  wire [8:0] next_led = {l9, l58[0], l58[1], l58[2], l58[3], l4, l3, l2, l1}; // R11

  // all indicators registered so they never glitch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      board_led <= 9'h000;
      activity_led <= 2'h0;
      control_status_register_err <= 1'b0;
    end else begin
      board_led <= next_led;
      activity_led <= next_act;
      control_status_register_err <= csr_err; // R23
    end
  end

endmodule // dcsl_top

// >>> dcsl_top_assertions.sv
`timescale 1ns/1ps
// ********
// led and status checks
// ********
module dcsl_chk import dcsl_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic proc_running,
  input wire logic disk_writing,
  input wire logic disk_reading,
  input wire logic host_init,
  input wire logic err_valid,
  input wire logic [7:0] error_code_register,
  input wire logic selftest_fail,
  input wire logic [3:0] selftest_code,
  input wire logic [8:0] board_led,
  input wire logic normal_mode,
  input wire logic [7:0] diag_select,
  input wire logic diag_start,
  input wire logic control_status_register_err
);
  // class as the operator reads it, indicator 5 first
  wire [3:0] cls = {board_led[4], board_led[5], board_led[6], board_led[7]};
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // leds lag one edge, so two settled edges are needed after reset
  property p_run;
    $past(hresetn, 2) && !$past(selftest_fail) |-> board_led[8] == $past(proc_running);
  endproperty
  a_run: assert property (p_run) else $error("run indicator wrong");
  property p_act;
    $past(hresetn, 2) && !$past(selftest_fail) |-> board_led[3:2] == $past({disk_reading, disk_writing});
  endproperty
  a_act: assert property (p_act) else $error("activity indicators wrong");
  property p_nrm;
    $past(hresetn, 2) && !$past(selftest_fail) |-> board_led[0] == normal_mode;
  endproperty
  a_nrm: assert property (p_nrm) else $error("mode indicator wrong");
  property p_self;
    $past(hresetn, 2) && $past(selftest_fail) |-> board_led[3:0] == 4'h2 && !board_led[8] && cls == $past(selftest_code);
  endproperty
  a_self: assert property (p_self) else $error("self-test pattern wrong");
  property p_cls;
    err_valid && error_code_register == 8'h40 ##1 !host_init && !err_valid && !selftest_fail |=> cls == 4'h1;
  endproperty
  a_cls: assert property (p_cls) else $error("operator class late or wrong");
  property p_clr;
    host_init && !err_valid ##1 !selftest_fail |=> cls == 4'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("class not cleared");
  property p_csr;
    err_valid && error_code_register == ERR_HDR_CRC ##1 !err_valid |=> !control_status_register_err;
  endproperty
  a_csr: assert property (p_csr) else $error("header error set status bit");
  property p_dia;
    diag_start |-> !normal_mode && diag_select != 8'h00;
  endproperty
  a_dia: assert property (p_dia) else $error("diagnostic start in normal mode");
  c_err: cover property (err_valid && error_code_register == 8'h40);
  c_self: cover property (selftest_fail);
  c_dia: cover property (diag_start);
endmodule // dcsl_chk

bind dcsl_top dcsl_chk dcsl_chk_i (.hclk, .hresetn, .proc_running, .disk_writing, .disk_reading, .host_init,
  .err_valid, .error_code_register, .selftest_fail, .selftest_code, .board_led, .normal_mode, .diag_select,
  .diag_start, .control_status_register_err);

// >>> dcsl_operator.sv
`timescale 1ns/1ps
// ********
// operator at the switch bank
// ********
module dcsl_operator (
  input wire logic [7:0] sw_set,
  input wire logic [8:0] board_led,
  output logic [7:0] switch_pins,
  output logic [3:0] seen_class
);
  // rockers set by hand, position n on bit n-1
  assign switch_pins = sw_set;
  // class read off indicators 5 to 8, indicator 5 weighs most
  assign seen_class = {board_led[4], board_led[5], board_led[6], board_led[7]};
endmodule // dcsl_operator

// >>> dcsl_top_test.sv
`timescale 1ns/1ps
// ********
// bench
// ********
module dcsl_top_test;
  import dcsl_pkg::*;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, proc_running = 1'h0, host_wait = 1'h0;
  logic disk_writing = 1'h0, disk_reading = 1'h0, host_init = 1'h0, err_valid = 1'h0, err_unit = 1'h0;
  logic selftest_fail = 1'h0, hreadyout, hresp, normal_mode, mode1_compat, unit_swap, two_drives, diag_start;
  logic csr_err;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0, activity_led;
  logic [7:0] error_code_register = 8'h0, sw_set = 8'h80, switch_pins, diag_select;
  logic [3:0] selftest_code = 4'h0, seen_class;
  logic [8:0] board_led;
  int fail_count = 0, cmp_count = 0, cyc = 0, n, dstarts = 0;
  // code then expected class; last two are unknown codes
  logic [11:0] rows [30] = '{12'h401, 12'hf01, 12'ha02, 12'ha82, 12'h203, 12'h984, 12'he84, 12'hb05,
    12'h686, 12'h607, 12'h808, 12'h389, 12'h509, 12'h589, 12'h709, 12'h789, 12'h48a, 12'h90b, 12'hd0b,
    12'hd8b, 12'he0c, 12'h08d, 12'h10d, 12'h18d, 12'h28d, 12'h88e, 12'hb8f, 12'hf8f, 12'h000, 12'hff0};
  // short flash half period keeps the two-minute stop within reach
  dcsl_top #(.FLASH_HALF(4)) dcsl_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .switch_pins, .proc_running, .host_wait,
    .disk_writing, .disk_reading, .host_init, .err_valid, .error_code_register, .err_unit,
    .head_loaded(2'h0), .selftest_fail, .selftest_code, .board_led, .activity_led, .normal_mode,
    .mode1_compat, .unit_swap, .two_drives, .diag_select, .diag_start, .control_status_register_err(csr_err));
  dcsl_operator dcsl_operator_i (.sw_set, .board_led, .switch_pins, .seen_class);
  // count start pulses; only the diagnostic power-up should give one
  always @(posedge hclk) if (diag_start === 1'h1) dstarts <= dstarts + 1;
  initial forever #5 hclk = ~hclk;
  // hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      close_out;
    end
  end
  task close_out;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // power-up with a switch setting, config settles in 6 edges
  task rst(input logic [7:0] s);
    @(posedge hclk);
    hresetn <= 1'h0;
    sw_set <= s;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (12) @(posedge hclk);
  endtask
  // single ahb-lite transfer, waits on hready in both phases
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    q = hrdata;
  endtask
  task err(input logic [7:0] c, input logic u);
    @(posedge hclk);
    err_valid <= 1'h1;
    error_code_register <= c;
    err_unit <= u;
    @(posedge hclk);
    err_valid <= 1'h0;
    repeat (3) @(posedge hclk);
  endtask
  task init;
    @(posedge hclk);
    host_init <= 1'h1;
    @(posedge hclk);
    host_init <= 1'h0;
    repeat (3) @(posedge hclk);
  endtask
  // flashing means the led is lit for some but not all of 16 cycles
  task fl(input int k, input logic e);
    n = 0;
    repeat (16) begin
      @(posedge hclk);
      n += activity_led[k];
    end
    chk(n > 0 && n < 16, e);
  endtask
  initial begin
    rst(8'h80);
    chk({normal_mode, mode1_compat, unit_swap, two_drives, diag_select}, 12'h900);
    ahb(1'h0, 32'h0, 32'h0, r);
    chk({hresp, r[12:0]}, 14'h1980);
    ahb(1'h0, 32'hc, 32'h0, r);
    chk(r, 32'h0);
    proc_running <= 1'h1;
    host_wait <= 1'h1;
    disk_writing <= 1'h1;
    repeat (3) @(posedge hclk);
    chk({board_led[8], board_led[3:0]}, 5'h17);
    $display("config and indicators done");
    // every code in the class table, cleared by init each time
    for (int i = 0; i < 30; i++) begin
      err(rows[i][11:4], 1'h0);
      chk(seen_class, rows[i][3:0]);
      chk(csr_err, rows[i][3:0] != 4'h0 && rows[i][11:4] != 8'h10 && rows[i][11:4] != 8'h60);
      init;
      chk(seen_class, 4'h0);
    end
    $display("class table done");
    sw_set <= 8'hff;
    repeat (10) @(posedge hclk);
    chk({normal_mode, diag_select}, 9'h100);
    err(8'h40, 1'h1);
    fl(1, 1'h1);
    repeat (1000) @(posedge hclk);
    fl(1, 1'h0);
    err(8'ha0, 1'h0);
    fl(0, 1'h0);
    err(8'h40, 1'h0);
    init;
    fl(0, 1'h0);
    err(8'h40, 1'h0);
    repeat (900) @(posedge hclk);
    err(8'h40, 1'h0);
    repeat (200) @(posedge hclk);
    fl(0, 1'h1);
    err(8'h20, 1'h0);
    ahb(1'h0, 32'h4, 32'h0, r);
    chk(r[12:0], 13'h1203);
    ahb(1'h1, 32'h8, 32'h3, r);
    repeat (3) @(posedge hclk);
    chk({csr_err, seen_class}, 5'h00);
    $display("flash and clear done");
    rst(8'h78);
    chk({normal_mode, mode1_compat, unit_swap, two_drives, diag_select}, 12'he00);
    err(8'h40, 1'h0);
    fl(1, 1'h1);
    selftest_fail <= 1'h1;
    selftest_code <= 4'h3;
    repeat (3) @(posedge hclk);
    chk(board_led, 9'h0c2);
    selftest_fail <= 1'h0;
    rst(8'h01);
    chk({normal_mode, diag_select}, 9'h001);
    chk(board_led[1:0], 2'h0);
    chk(dstarts, 32'h1);
    $display("mapping, self-test and diagnostic done");
    close_out;
  end
endmodule // dcsl_top_test
